// file: rtl/fpe_flash_seq.sv
// flash program/erase sequencer: apb registers, unlock key, cycle control
// assumes an apb master on pclk and a flash array that follows flash_req
//
// Function
// - code 0x4008 writes a config word, 0x4004 a data word
// - code 0x4005 writes a 16-word data row, 0x4001 a 32-word code row
// - the cycle-start bit ignores a set without a prior unlock
// - key 0x55 then 0xaa unlocks the cycle-start bit
// - key bytes are accepted whatever register sourced them
// - setting start once unlocked begins the selected operation
// - clearing start ends the cycle; the device does not time it
// - code 0x407f bulk-erases all memories and code-protect bits
// - in low supply segment config registers cannot be erased
// - general segment bits return to one only by bulk or segment erase
// - serial command code shifts least significant bit first
// - code row programs 32 words from fully loaded write latches
// - code 0x4071 erases one 32-word code row
// - code 0x4075 erases a 16-word data row, 0x4074 one data word
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module fpe_flash_seq
  import fpe_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        programming_clock_pin,
  input  wire logic        programming_data_pin,
  input  wire logic        low_supply_pin,
  input  wire logic [4:0]  latch_rd_idx,
  output logic      [23:0] latch_rd_data,
  output fpe_flash_req_t   flash_req
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0]           ctrl, next_ctrl;
  fpe_key_t              key_st, next_key_st;
  logic [15:0]           adr_lo, next_adr_lo;
  logic [7:0]            adr_hi, next_adr_hi;
  logic [7:0]            table_page_register, next_table_page_register;
  logic [15:0]           wrptr, next_wrptr;
  logic [FPE_INSN_W-1:0] latch [FPE_ROW_WORDS];
  logic [FPE_INSN_W-1:0] next_latch [FPE_ROW_WORDS];
  logic [4:0]            lidx, next_lidx;
  logic                  lfull, next_lfull;
  logic                  refused, next_refused;
  logic [15:0]           gseg, next_gseg;
  fpe_serial_t           ser, next_ser;
  fpe_flash_req_t        next_req;
  logic [31:0]           next_prdata;
  logic                  next_pready, next_pslverr;
  logic [23:0]           next_lrd;
  logic                  low_s1, low_sync;
  fpe_serial_t           rx_word;
  logic                  rx_valid;
  logic                  setup, wr_acc;
  fpe_op_t               op;
  logic                  ok;

  fpe_serial_rx u_rx (
    .pclk                  (pclk),
    .presetn               (presetn),
    .programming_clock_pin (programming_clock_pin),
    .programming_data_pin  (programming_data_pin),
    .rx_word               (rx_word),
    .rx_valid              (rx_valid)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_s1   <= 1'b0;
      low_sync <= 1'b0;
    end else begin
      low_s1   <= low_supply_pin;
      low_sync <= low_s1;
    end
  end

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_ctrl    = ctrl;
    next_key_st  = key_st;
    next_adr_lo  = adr_lo;
    next_adr_hi  = adr_hi;
    next_table_page_register  = table_page_register;
    next_wrptr   = wrptr;
    next_latch   = latch;
    next_lidx    = lidx;
    next_lfull   = lfull;
    next_refused = refused;
    next_gseg    = gseg;
    next_ser     = ser;
    next_req     = flash_req;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_lrd     = latch[latch_rd_idx];
    op           = FPE_OP_NONE;
    ok           = 1'b0;
    // read data is prepared in the setup cycle; zero wait states
    if (setup) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
        FPE_OFS_CTRL:   next_prdata[15:0] = ctrl;
        FPE_OFS_KEY:    next_prdata = 32'h0000_0000;
        FPE_OFS_ADR_LO: next_prdata[15:0] = adr_lo;
        FPE_OFS_ADR_HI: next_prdata[7:0] = adr_hi;
        FPE_OFS_TABLE_PAGE_REGISTER: next_prdata[7:0] = table_page_register;
        FPE_OFS_WRPTR:  next_prdata[15:0] = wrptr;
        FPE_OFS_LATCH:  next_prdata[4:0] = lidx;
        FPE_OFS_STATUS: next_prdata[12:0] = {lidx, 2'b00, low_sync,
                          lfull, flash_req.active,
                          key_st == FPE_KEY_GOT1,
                          key_st == FPE_KEY_UNLOCKED, refused};
        FPE_OFS_GSEG:   next_prdata[15:0] = gseg;
        FPE_OFS_SERIAL: next_prdata[27:0] = ser;
        default:        next_pslverr = 1'b1;
      endcase
    end
    if (rx_valid) begin
      next_ser = rx_word;
    end
    if (wr_acc) begin
      case (paddr)
        FPE_OFS_KEY: begin
          // only the value counts, never the source of the write
          if (key_st == FPE_KEY_LOCKED && pwdata[7:0] == FPE_KEY1) begin
            next_key_st = FPE_KEY_GOT1;
          end else if (key_st == FPE_KEY_GOT1 &&
                       pwdata[7:0] == FPE_KEY2) begin
            next_key_st = FPE_KEY_UNLOCKED;
          end else if (key_st != FPE_KEY_UNLOCKED) begin
            next_key_st = FPE_KEY_LOCKED;
          end
        end
        FPE_OFS_ADR_LO: next_adr_lo = pwdata[15:0];
        FPE_OFS_ADR_HI: next_adr_hi = pwdata[7:0];
        FPE_OFS_TABLE_PAGE_REGISTER: next_table_page_register = pwdata[7:0];
        FPE_OFS_WRPTR: begin
          next_wrptr = pwdata[15:0];
          next_lidx  = 5'h00;
          next_lfull = 1'b0;
        end
        FPE_OFS_LATCH: begin
          if (!flash_req.active) begin
            next_latch[lidx] = pwdata[FPE_INSN_W-1:0];
            next_lidx        = lidx + 5'h01;
            if (lidx == FPE_LAST_IDX) begin
              next_lfull = 1'b1;
            end
          end
        end
        FPE_OFS_STATUS: begin
          if (pwdata[FPE_ST_REFUSED]) begin
            next_refused = 1'b0;
          end
        end
        FPE_OFS_CTRL: begin
          if (!flash_req.active) begin
            next_ctrl[14:0] = pwdata[14:0];
          end
          if (pwdata[FPE_WR_BIT]) begin
            next_key_st = FPE_KEY_LOCKED;
            if (key_st == FPE_KEY_UNLOCKED && !flash_req.active) begin
              op = fpe_decode(next_ctrl[14:0]);
              ok = (op != FPE_OP_NONE) &&
                   !(low_sync && (op == FPE_OP_SEG_ERASE ||
                                  op == FPE_OP_BULK)) &&
                   !(op == FPE_OP_CODE_ROW && !lfull);
              if (ok) begin
                next_ctrl[FPE_WR_BIT] = 1'b1;
                next_req.active = 1'b1;
                next_req.op     = op;
                if (op == FPE_OP_ROW_ERASE || op == FPE_OP_DROW_ERASE ||
                    op == FPE_OP_DWORD_ERASE) begin
                  next_req.addr = {adr_hi, adr_lo};
                end else begin
                  next_req.addr = {table_page_register, wrptr};
                end
                if (op == FPE_OP_CFG_WORD) begin
                  next_gseg = gseg & latch[0][15:0];
                end else if (op == FPE_OP_BULK ||
                             op == FPE_OP_SEG_ERASE) begin
                  next_gseg = FPE_GSEG_RST;
                end
              end else begin
                next_refused = 1'b1;
              end
            end
            // without an unlock the start bit stays as it was
          end else if (flash_req.active) begin
            next_ctrl[FPE_WR_BIT] = 1'b0;
            next_req.active       = 1'b0;
            if (flash_req.op == FPE_OP_CODE_ROW) begin
              next_lidx  = 5'h00;
              next_lfull = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl          <= FPE_CTRL_RST;
      key_st        <= FPE_KEY_LOCKED;
      adr_lo        <= 16'h0000;
      adr_hi        <= 8'h00;
      table_page_register        <= 8'h00;
      wrptr         <= 16'h0000;
      latch         <= '{default: '0};
      lidx          <= 5'h00;
      lfull         <= 1'b0;
      refused       <= 1'b0;
      gseg          <= FPE_GSEG_RST;
      ser           <= '0;
      flash_req     <= '0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      latch_rd_data <= 24'h00_0000;
    end else begin
      ctrl          <= next_ctrl;
      key_st        <= next_key_st;
      adr_lo        <= next_adr_lo;
      adr_hi        <= next_adr_hi;
      table_page_register        <= next_table_page_register;
      wrptr         <= next_wrptr;
      latch         <= next_latch;
      lidx          <= next_lidx;
      lfull         <= next_lfull;
      refused       <= next_refused;
      gseg          <= next_gseg;
      ser           <= next_ser;
      flash_req     <= next_req;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      latch_rd_data <= next_lrd;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ctrl_wr;
  assign ctrl_wr = wr_acc && paddr == FPE_OFS_CTRL;

  a_start_needs_key: assert property (
    $rose(flash_req.active) |-> $past(key_st) == FPE_KEY_UNLOCKED)
    else $error("cycle started without unlock");
  a_relock_after_set: assert property (
    ctrl_wr && pwdata[FPE_WR_BIT] |=> key_st == FPE_KEY_LOCKED)
    else $error("start bit not relocked");
  a_key_order: assert property (
    key_st == FPE_KEY_UNLOCKED && $past(key_st) != FPE_KEY_UNLOCKED |->
    $past(wr_acc && paddr == FPE_OFS_KEY && pwdata[7:0] == FPE_KEY2 &&
          key_st == FPE_KEY_GOT1))
    else $error("unlock without key pair");
  a_bad_key_drop: assert property (
    wr_acc && paddr == FPE_OFS_KEY && key_st == FPE_KEY_GOT1 &&
    pwdata[7:0] != FPE_KEY2 |=> key_st == FPE_KEY_LOCKED)
    else $error("partial key kept");
  a_clear_ends: assert property (
    ctrl_wr && !pwdata[FPE_WR_BIT] && flash_req.active
    |=> !flash_req.active && !ctrl[FPE_WR_BIT])
    else $error("cycle not ended by clear");
  a_cycle_holds: assert property (
    flash_req.active && !ctrl_wr |=> flash_req.active)
    else $error("cycle ended on its own");
  a_op_matches: assert property (
    $rose(flash_req.active) |->
    flash_req.op == fpe_decode(ctrl[14:0]) && ctrl[FPE_WR_BIT])
    else $error("operation differs from select code");
  a_low_refuse: assert property (
    $rose(flash_req.active) && $past(low_sync) |->
    flash_req.op != FPE_OP_SEG_ERASE && flash_req.op != FPE_OP_BULK)
    else $error("segment erase in low supply");
  a_row_full: assert property (
    $rose(flash_req.active) && flash_req.op == FPE_OP_CODE_ROW |->
    $past(lfull))
    else $error("code row without full latches");
  a_gseg_rise: assert property (
    |(gseg & ~$past(gseg)) |-> $rose(flash_req.active) &&
    (flash_req.op == FPE_OP_BULK || flash_req.op == FPE_OP_SEG_ERASE))
    else $error("config bit set without erase");

  c_bulk: cover property ($rose(flash_req.active) &&
                          flash_req.op == FPE_OP_BULK);
  c_code_row: cover property ($rose(flash_req.active) &&
                              flash_req.op == FPE_OP_CODE_ROW);
  c_refused: cover property ($rose(refused));
  c_serial: cover property (rx_valid && rx_word.cmd == FPE_CMD_EXEC);

endmodule

// file: rtl/fpe_pkg.sv
// package for the flash program/erase sequencer: offsets, codes, types
// assumes a 32-bit apb register bus and a two-pin serial programming link
package fpe_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] FPE_OFS_CTRL   = 8'h00;
  localparam logic [7:0] FPE_OFS_KEY    = 8'h04;
  localparam logic [7:0] FPE_OFS_ADR_LO = 8'h08;
  localparam logic [7:0] FPE_OFS_ADR_HI = 8'h0c;
  localparam logic [7:0] FPE_OFS_TABLE_PAGE_REGISTER = 8'h10;
  localparam logic [7:0] FPE_OFS_WRPTR  = 8'h14;
  localparam logic [7:0] FPE_OFS_LATCH  = 8'h18;
  localparam logic [7:0] FPE_OFS_STATUS = 8'h1c;
  localparam logic [7:0] FPE_OFS_GSEG   = 8'h20;
  localparam logic [7:0] FPE_OFS_SERIAL = 8'h24;

  // ----------------------------------------------------------------------
  // fields, reset values, key bytes
  // ----------------------------------------------------------------------
  localparam int unsigned FPE_WR_BIT   = 15;
  localparam logic [15:0] FPE_CTRL_RST = 16'h0000;
  localparam logic [15:0] FPE_GSEG_RST = 16'hffff;
  localparam logic [7:0]  FPE_KEY1     = 8'h55;
  localparam logic [7:0]  FPE_KEY2     = 8'haa;
  localparam int unsigned FPE_ST_REFUSED = 0;
  localparam int unsigned FPE_ROW_WORDS  = 32;
  localparam int unsigned FPE_INSN_W     = 24;
  localparam logic [4:0]  FPE_LAST_IDX   = 5'h1f;
  localparam int unsigned FPE_CMD_W      = 4;
  localparam int unsigned FPE_FRAME_W    = 28;
  localparam logic [4:0]  FPE_FRAME_LAST = 5'h1b;
  localparam logic [3:0]  FPE_CMD_EXEC   = 4'h0;

  // ----------------------------------------------------------------------
  // operation select codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] FPE_C_CFG_WORD   = 16'h4008;
  localparam logic [15:0] FPE_C_DATA_WORD  = 16'h4004;
  localparam logic [15:0] FPE_C_DATA_ROW   = 16'h4005;
  localparam logic [15:0] FPE_C_CODE_ROW   = 16'h4001;
  localparam logic [15:0] FPE_C_BULK       = 16'h407f;
  localparam logic [15:0] FPE_C_ROW_ERASE  = 16'h4071;
  localparam logic [15:0] FPE_C_DROW_ERASE = 16'h4075;
  localparam logic [15:0] FPE_C_DWORD_ERA  = 16'h4074;
  localparam logic [15:0] FPE_C_EXEC_ERASE = 16'h4072;
  localparam logic [15:0] FPE_C_SEG_BSG    = 16'h406e;
  localparam logic [15:0] FPE_C_SEG_SG     = 16'h405e;
  localparam logic [15:0] FPE_C_SEG_G      = 16'h404e;
  localparam logic [15:0] FPE_C_DSEG_B     = 16'h4066;
  localparam logic [15:0] FPE_C_DSEG_S     = 16'h4056;
  localparam logic [15:0] FPE_C_DSEG_G     = 16'h4046;

  typedef enum logic [3:0] {
    FPE_OP_NONE, FPE_OP_CFG_WORD, FPE_OP_DATA_WORD, FPE_OP_DATA_ROW,
    FPE_OP_CODE_ROW, FPE_OP_BULK, FPE_OP_ROW_ERASE, FPE_OP_DROW_ERASE,
    FPE_OP_DWORD_ERASE, FPE_OP_EXEC_ERASE, FPE_OP_SEG_ERASE,
    FPE_OP_DSEG_ERASE
  } fpe_op_t;

  typedef enum logic [1:0] {
    FPE_KEY_LOCKED, FPE_KEY_GOT1, FPE_KEY_UNLOCKED
  } fpe_key_t;

  typedef struct packed {
    logic                  active;
    fpe_op_t               op;
    logic [FPE_INSN_W-1:0] addr;
  } fpe_flash_req_t;

  typedef struct packed {
    logic [FPE_CMD_W-1:0]  cmd;
    logic [FPE_INSN_W-1:0] payload;
  } fpe_serial_t;

  // maps the low 15 bits of the control register onto an operation
  function automatic fpe_op_t fpe_decode(input logic [14:0] c);
    fpe_op_t r;
    r = FPE_OP_NONE;
    case (c)
      FPE_C_CFG_WORD[14:0]:   r = FPE_OP_CFG_WORD;
      FPE_C_DATA_WORD[14:0]:  r = FPE_OP_DATA_WORD;
      FPE_C_DATA_ROW[14:0]:   r = FPE_OP_DATA_ROW;
      FPE_C_CODE_ROW[14:0]:   r = FPE_OP_CODE_ROW;
      FPE_C_BULK[14:0]:       r = FPE_OP_BULK;
      FPE_C_ROW_ERASE[14:0]:  r = FPE_OP_ROW_ERASE;
      FPE_C_DROW_ERASE[14:0]: r = FPE_OP_DROW_ERASE;
      FPE_C_DWORD_ERA[14:0]:  r = FPE_OP_DWORD_ERASE;
      FPE_C_EXEC_ERASE[14:0]: r = FPE_OP_EXEC_ERASE;
      FPE_C_SEG_BSG[14:0],
      FPE_C_SEG_SG[14:0],
      FPE_C_SEG_G[14:0]:      r = FPE_OP_SEG_ERASE;
      FPE_C_DSEG_B[14:0],
      FPE_C_DSEG_S[14:0],
      FPE_C_DSEG_G[14:0]:     r = FPE_OP_DSEG_ERASE;
      default:                r = FPE_OP_NONE;
    endcase
    return r;
  endfunction

endpackage

// file: rtl/fpe_serial_rx.sv
// serial instruction receiver on the two-pin programming link
// assumes link pins are asynchronous to pclk and much slower than it
`timescale 1ns/10ps
module fpe_serial_rx
  import fpe_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        programming_clock_pin,
  input  wire logic        programming_data_pin,
  output fpe_serial_t      rx_word,
  output logic             rx_valid
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic             clk_s1, clk_s2, clk_s3;
  logic             dat_s1, dat_s2;
  logic [FPE_FRAME_W-1:0] sr, next_sr;
  logic [4:0]       cnt, next_cnt;
  logic             next_valid;
  logic             rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      clk_s1 <= programming_clock_pin;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= programming_data_pin;
      dat_s2 <= dat_s1;
    end
  end

  // ----------------------------------------------------------------------
  // shifter: command then payload, each least significant bit first
  // ----------------------------------------------------------------------
  assign rise = clk_s2 & ~clk_s3;

  always_comb begin
    next_sr    = sr;
    next_cnt   = cnt;
    next_valid = 1'b0;
    if (rise) begin
      next_sr = {dat_s2, sr[FPE_FRAME_W-1:1]};
      if (cnt == FPE_FRAME_LAST) begin
        next_cnt   = 5'h00;
        next_valid = 1'b1;
      end else begin
        next_cnt = cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr       <= '0;
      cnt      <= 5'h00;
      rx_valid <= 1'b0;
    end else begin
      sr       <= next_sr;
      cnt      <= next_cnt;
      rx_valid <= next_valid;
    end
  end

  assign rx_word = fpe_serial_t'({sr[FPE_CMD_W-1:0],
                                  sr[FPE_FRAME_W-1:FPE_CMD_W]});

endmodule

// file: verif/fpe_prog_model.sv
// programmer model driving the two-pin serial programming link
// assumes frames of 4 command bits then 24 payload bits, lsb first
`timescale 1ns/10ps
module fpe_prog_model
  import fpe_pkg::*;
(
  output logic programming_clock_pin,
  output logic programming_data_pin
);
  initial begin
    programming_clock_pin = 1'b0;
    programming_data_pin  = 1'b0;
  end

  // ----------------------------------------------------------------------
  // frame sender: link clock stands low between frames
  // ----------------------------------------------------------------------
  task automatic send(input fpe_serial_t f);
    logic [FPE_FRAME_W-1:0] b;
    // command nibble goes out first, so it sits in the low bits
    b = {f.payload, f.cmd};
    #13;
    for (int i = 0; i < FPE_FRAME_W; i++) begin
      programming_data_pin = b[i];
      #400 programming_clock_pin = 1'b1;
      #400 programming_clock_pin = 1'b0;
    end
    // released data line shows the inverse of the last bit
    programming_data_pin = ~b[FPE_FRAME_W-1];
  endtask
endmodule

// file: verif/test_flash_nvm_program_erase_control.sv
// testbench for the flash program/erase sequencer
// assumes the programmer model on the link pins and apb at 10 MHz
`timescale 1ns/10ps
module test_flash_nvm_program_erase_control
  import fpe_pkg::*;
;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata, r;
  logic           pready, pslverr, e, low_supply_pin = 0;
  logic [4:0]     latch_rd_idx = 5'h00;
  logic [23:0]    latch_rd_data;
  logic           programming_clock_pin, programming_data_pin;
  fpe_flash_req_t flash_req;
  int             errors = 0, n_compared = 0, cycles = 0;
  logic [27:0]    frm [4] = '{28'h0040100, 28'h0040100, 28'h0, 28'h68a31c5};

  always #50 pclk = ~pclk;

  fpe_flash_seq dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .programming_clock_pin(programming_clock_pin),
    .programming_data_pin(programming_data_pin),
    .low_supply_pin(low_supply_pin), .latch_rd_idx(latch_rd_idx),
    .latch_rd_data(latch_rd_data), .flash_req(flash_req));
  fpe_prog_model prog_u (.programming_clock_pin(programming_clock_pin),
    .programming_data_pin(programming_data_pin));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      complete_run;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic unlock;
    apb(1, FPE_OFS_KEY, 32'h1234ff55);
    apb(1, FPE_OFS_KEY, 32'h987600aa);
  endtask

  task automatic cyc(input logic [15:0] code, input fpe_op_t op,
                     input logic [23:0] ad, input int hold);
    unlock;
    apb(1, FPE_OFS_CTRL, {16'h0, code | 16'h8000});
    repeat (hold) @(posedge pclk);
    #1;
    chk("active", 32'(flash_req.active), 1);
    chk("op", 32'(flash_req.op), 32'(op));
    chk("addr", 32'(flash_req.addr), 32'(ad));
    apb(1, FPE_OFS_CTRL, {16'h0, code});
    settle;
    chk("stop", 32'(flash_req.active), 0);
    apb(1, FPE_OFS_CTRL, {16'h0, code | 16'h8000});
    settle;
    chk("relock", 32'(flash_req.active), 0);
  endtask

  task automatic refuse(input logic [15:0] code);
    apb(1, FPE_OFS_STATUS, 32'h1);
    unlock;
    apb(1, FPE_OFS_CTRL, {16'h0, code | 16'h8000});
    settle;
    chk("no start", 32'(flash_req.active), 0);
    apb(0, FPE_OFS_STATUS, 0);
    chk("refused", r & 32'h1, 1);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, FPE_OFS_CTRL, 0);
    chk("ctrl rst", r, {16'h0, FPE_CTRL_RST});
    apb(0, FPE_OFS_GSEG, 0);
    chk("gseg rst", r, {16'h0, FPE_GSEG_RST});
    apb(0, 8'h30, 0);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    $display("test reset done");
    apb(1, FPE_OFS_CTRL, 32'hc071);
    settle;
    chk("locked", 32'(flash_req.active), 0);
    apb(1, FPE_OFS_KEY, 32'h55);
    apb(1, FPE_OFS_KEY, 32'h12);
    apb(1, FPE_OFS_KEY, 32'haa);
    apb(1, FPE_OFS_CTRL, 32'hc071);
    settle;
    chk("bad key", 32'(flash_req.active), 0);
    $display("test lock done");
    apb(1, FPE_OFS_ADR_HI, 0);
    apb(1, FPE_OFS_ADR_LO, 32'h40);
    apb(1, FPE_OFS_TABLE_PAGE_REGISTER, 32'h12);
    apb(1, FPE_OFS_WRPTR, 32'h3400);
    for (int i = 0; i < FPE_ROW_WORDS; i++) begin
      apb(1, FPE_OFS_LATCH, {8'h0, 8'h5a, 8'(i), 8'(~i)});
    end
    latch_rd_idx <= 5'h1f;
    settle;
    chk("latch 31", 32'(latch_rd_data), 32'h5a1fe0);
    apb(0, FPE_OFS_STATUS, 0);
    chk("full", r & 32'h10, 32'h10);
    cyc(FPE_C_ROW_ERASE, FPE_OP_ROW_ERASE, 24'h000040, 2);
    cyc(FPE_C_CFG_WORD, FPE_OP_CFG_WORD, 24'h123400, 2);
    apb(0, FPE_OFS_GSEG, 0);
    chk("gseg clr", r, 32'h00ff);
    cyc(FPE_C_CODE_ROW, FPE_OP_CODE_ROW, 24'h123400, 2);
    refuse(FPE_C_CODE_ROW);
    cyc(FPE_C_DATA_WORD, FPE_OP_DATA_WORD, 24'h123400, 2);
    cyc(FPE_C_DATA_ROW, FPE_OP_DATA_ROW, 24'h123400, 2);
    cyc(FPE_C_DROW_ERASE, FPE_OP_DROW_ERASE, 24'h000040, 2);
    cyc(FPE_C_DWORD_ERA, FPE_OP_DWORD_ERASE, 24'h000040, 2);
    cyc(FPE_C_BULK, FPE_OP_BULK, 24'h123400, 20000);
    apb(0, FPE_OFS_GSEG, 0);
    chk("gseg bulk", r, 32'hffff);
    cyc(FPE_C_CFG_WORD, FPE_OP_CFG_WORD, 24'h123400, 2);
    apb(0, FPE_OFS_GSEG, 0);
    chk("gseg clr2", r, 32'h00ff);
    cyc(FPE_C_SEG_G, FPE_OP_SEG_ERASE, 24'h123400, 2);
    apb(0, FPE_OFS_GSEG, 0);
    chk("gseg seg", r, 32'hffff);
    cyc(FPE_C_EXEC_ERASE, FPE_OP_EXEC_ERASE, 24'h123400, 2);
    cyc(FPE_C_DSEG_B, FPE_OP_DSEG_ERASE, 24'h123400, 2);
    $display("test cycles done");
    low_supply_pin <= 1;
    settle;
    refuse(FPE_C_BULK);
    refuse(FPE_C_SEG_G);
    apb(1, FPE_OFS_ADR_LO, 32'h80);
    cyc(FPE_C_ROW_ERASE, FPE_OP_ROW_ERASE, 24'h000080, 2);
    low_supply_pin <= 0;
    $display("test low supply done");
    for (int i = 0; i < 4; i++) begin
      prog_u.send(frm[i]);
      repeat (8) @(posedge pclk);
      apb(0, FPE_OFS_SERIAL, 0);
      chk("frame", r, {4'h0, frm[i]});
    end
    $display("test link done");
    complete_run;
  end
endmodule
